// ===== src/lp_timer_pkg.sv
// Purpose: Shared constants for the sixteen-bit timer with LP oscillator
// Assumes: One system clock; byte access strobes come from the CPU side
// Notes:   Control bits arrive as plain ports, no register bus
// What this block does
// - Wide access mode maps the high-byte address onto a holding buffer
// - Wide mode low-byte read copies live high byte into the buffer
// - Wide mode low-byte write loads high byte from buffer simultaneously
// - Wide mode never reads or writes the live high byte directly
// - High-byte write keeps prescaler; low-byte write clears prescaler
// - LP oscillator runs only while its enable bit is set
// - Enabled LP oscillator keeps running in every power-managed mode
// - Clock select 01 clocks CPU and peripherals from LP oscillator unless clock monitor fails
// - Status flag high exactly while LP oscillator supplies system clock
// - Counter counts up, wraps to zero, wrap sets overflow flag
// - Overflow flag forwarded as interrupt request only while enabled
// - Compare special event trigger (mode 1011) resets the counter
// - Special event reset guaranteed only in timer or synchronous mode
// - Software write coinciding with trigger reset wins over the reset
// - Special event reset never sets the overflow flag
// - Second compare unit trigger also starts conversion if ADC enabled
// - Async mode: after update, falling edge arms next counted rising edge
// - Internal source counts per instruction cycle, else rising edges
// - Prescale codes 00..11 divide count clock by 1, 2, 4, 8
// - Sync bypass bit only matters for external clock source
// - Counter counts only while its on bit is set
package lp_timer_pkg;
    localparam int          COUNT_W          = 16;
    localparam int          BYTE_W           = 8;
    localparam int          PRESC_W          = 3;
    localparam int          SEL_W            = 2;
    localparam int          MODE_W           = 4;
    localparam logic [15:0] COUNT_MAX        = 16'hffff;
    localparam logic [15:0] COUNT_ONE        = 16'h0001;
    localparam logic [15:0] COUNT_RESET      = 16'h0000;
    localparam logic [3:0]  MODE_SPECIAL_EVT = 4'hb;
    localparam logic [1:0]  SYSCLK_SEL_LP    = 2'h1;
    localparam int          SRC_PIN          = 0;
    localparam int          SRC_OSC          = 1;
endpackage

// ===== src/lp_timer_sync.sv
// Purpose: Two-flop synchroniser for asynchronous count inputs
// Assumes: Inputs are slow levels from pins or the LP oscillator
// Notes:   Only the second stage leaves this module
`timescale 1ns/1ns
`default_nettype none
module lp_timer_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_clk_en,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    always_comb begin
        next_st        = st;
        next_st.stage1 = i_async;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            st <= '0;
        end else if (i_clk_en) begin
            st <= next_st;
        end
    end

    assign o_sync = st.stage2;
endmodule
`default_nettype wire

// ===== src/lp_timer_prescaler.sv
// Purpose: Power-of-two input prescaler for the count clock
// Assumes: i_tick is a one-cycle pulse on the system clock
// Notes:   o_tick is combinational from the stored count, i_select and i_tick
`timescale 1ns/1ns
`default_nettype none
module lp_timer_prescaler
    import lp_timer_pkg::*;
(
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_clk_en,
    input  wire logic             i_clear,
    input  wire logic [SEL_W-1:0] i_select,
    input  wire logic             i_tick,
    output logic                  o_tick
);
    typedef struct packed {
        logic [PRESC_W-1:0] count;
    } presc_state_t;

    presc_state_t       st;
    presc_state_t       next_st;
    logic [PRESC_W-1:0] last;

    // Divide by 1, 2, 4, 8
    always_comb begin
        last   = PRESC_W'((1 << i_select) - 1);
        o_tick = i_tick && (st.count >= last);
    end

    always_comb begin
        next_st = st;
        if (i_clear) begin
            next_st.count = '0;
        end else if (o_tick) begin
            next_st.count = '0;
        end else if (i_tick) begin
            next_st.count = st.count + PRESC_W'(1);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            st <= '0;
        end else if (i_clk_en) begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

// ===== src/lp_timer.sv
// Purpose: Sixteen-bit up counter with buffered byte access and LP osc
// Assumes: Byte strobes and control bits are on the system clock
// Notes:   Async mode is approximated on the system clock after sync
`timescale 1ns/1ns
`default_nettype none
module lp_timer
    import lp_timer_pkg::*;
(
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_clk_en,
    input  wire logic              i_rd_low,
    input  wire logic              i_rd_high,
    input  wire logic              i_wr_low,
    input  wire logic              i_wr_high,
    input  wire logic [BYTE_W-1:0] i_wdata,
    input  wire logic              i_wide_access_enable,
    input  wire logic              i_counter_on,
    input  wire logic              i_count_source_select,
    input  wire logic              i_ext_sync_bypass,
    input  wire logic [SEL_W-1:0]  i_input_prescale_select,
    input  wire logic              i_lp_osc_enable,
    input  wire logic              i_overflow_irq_enable,
    input  wire logic              i_overflow_flag_clear,
    input  wire logic [SEL_W-1:0]  i_system_clock_select,
    input  wire logic              i_clock_monitor_fail,
    input  wire logic              i_insn_tick,
    input  wire logic              i_ext_clk_pin,
    input  wire logic              i_lp_osc_clk,
    input  wire logic [MODE_W-1:0] i_cmp1_mode,
    input  wire logic              i_cmp1_uses_timer,
    input  wire logic              i_cmp1_match,
    input  wire logic [MODE_W-1:0] i_cmp2_mode,
    input  wire logic              i_cmp2_uses_timer,
    input  wire logic              i_cmp2_match,
    input  wire logic              i_adc_enable,
    output logic [BYTE_W-1:0]      o_rdata,
    output logic [COUNT_W-1:0]     o_count,
    output logic                   o_overflow_irq_flag,
    output logic                   o_overflow_irq_req,
    output logic                   o_lp_osc_enable,
    output logic                   o_sec_run_mode,
    output logic                   o_sysclk_from_lp_osc_flag,
    output logic                   o_adc_start
);
    typedef struct packed {
        logic [COUNT_W-1:0] count;
        logic [BYTE_W-1:0]  hold_buf;
        logic [BYTE_W-1:0]  rdata;
        logic               ovf_flag;
        logic               irq_req;
        logic               osc_en;
        logic               sec_run;
        logic               sysclk_flag;
        logic               adc_start;
        logic               armed;
        logic               prev_src;
    } timer_state_t;

    timer_state_t st;
    timer_state_t next_st;

    logic [1:0] synced;
    logic       ext_level;
    logic       src_rise;
    logic       src_fall;
    logic       async_mode;
    logic       raw_tick;
    logic       presc_tick;
    logic       any_write;
    logic       cmp1_evt;
    logic       cmp2_evt;
    logic       evt_reset;
    logic       wrap;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers and prescaler

    lp_timer_sync #(
        .WIDTH (2)
    ) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_clk_en  (i_clk_en),
        .i_async   ({i_lp_osc_clk, i_ext_clk_pin}),
        .o_sync    (synced)
    );

    lp_timer_prescaler u_presc (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_clk_en  (i_clk_en),
        .i_clear   (i_wr_low),
        .i_select  (i_input_prescale_select),
        .i_tick    (raw_tick),
        .o_tick    (presc_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Count source selection

    always_comb begin
        ext_level  = i_lp_osc_enable ? synced[SRC_OSC] : synced[SRC_PIN];
        src_rise   = ext_level && !st.prev_src;
        src_fall   = !ext_level && st.prev_src;
        async_mode = i_count_source_select && i_ext_sync_bypass;
        any_write  = i_wr_low || i_wr_high;
        raw_tick   = 1'b0;
        if (i_counter_on) begin
            if (!i_count_source_select) begin
                raw_tick = i_insn_tick;
            end else if (async_mode) begin
                raw_tick = src_rise && st.armed;
            end else begin
                raw_tick = src_rise;
            end
        end
    end

    // Special event triggers, qualified by compare mode
    always_comb begin
        cmp1_evt  = i_cmp1_match && i_cmp1_uses_timer
                    && (i_cmp1_mode == MODE_SPECIAL_EVT);
        cmp2_evt  = i_cmp2_match && i_cmp2_uses_timer
                    && (i_cmp2_mode == MODE_SPECIAL_EVT);
        // Write wins; async mode drops the reset
        evt_reset = (cmp1_evt || cmp2_evt) && !any_write
                    && !async_mode;
        wrap      = presc_tick && !any_write && !evt_reset
                    && (st.count == COUNT_MAX);
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_st           = st;
        next_st.adc_start = cmp2_evt && i_adc_enable;
        next_st.prev_src  = ext_level;
        next_st.osc_en    = i_lp_osc_enable;
        next_st.sec_run   = (i_system_clock_select == SYSCLK_SEL_LP)
                            && !i_clock_monitor_fail;
        next_st.sysclk_flag = next_st.sec_run;

        if (async_mode && any_write) begin
            next_st.armed = 1'b0;
        end else if (src_fall) begin
            next_st.armed = 1'b1;
        end

        if (i_rd_low) begin
            next_st.rdata = st.count[BYTE_W-1:0];
            if (i_wide_access_enable) begin
                next_st.hold_buf = st.count[COUNT_W-1:BYTE_W];
            end
        end else if (i_rd_high) begin
            next_st.rdata = i_wide_access_enable ? st.hold_buf
                          : st.count[COUNT_W-1:BYTE_W];
        end

        if (any_write) begin
            if (i_wr_high) begin
                if (i_wide_access_enable) begin
                    next_st.hold_buf = i_wdata;
                end else begin
                    next_st.count[COUNT_W-1:BYTE_W] = i_wdata;
                end
            end
            if (i_wr_low) begin
                next_st.count[BYTE_W-1:0] = i_wdata;
                if (i_wide_access_enable) begin
                    next_st.count[COUNT_W-1:BYTE_W] = st.hold_buf;
                end
            end
        end else if (evt_reset) begin
            next_st.count = COUNT_RESET;
        end else if (presc_tick) begin
            next_st.count = st.count + COUNT_ONE;
        end

        // Hardware set wins over software clear
        if (i_overflow_flag_clear) begin
            next_st.ovf_flag = 1'b0;
        end
        if (wrap) begin
            next_st.ovf_flag = 1'b1;
        end
        next_st.irq_req = next_st.ovf_flag && i_overflow_irq_enable;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            st <= '0;
        end else if (i_clk_en) begin
            st <= next_st;
        end
    end

    always_comb begin
        o_rdata                   = st.rdata;
        o_count                   = st.count;
        o_overflow_irq_flag       = st.ovf_flag;
        o_overflow_irq_req        = st.irq_req;
        o_lp_osc_enable           = st.osc_en;
        o_sec_run_mode            = st.sec_run;
        o_sysclk_from_lp_osc_flag = st.sysclk_flag;
        o_adc_start               = st.adc_start;
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    a_wrap_sets_flag: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clk_en && wrap) |=> (st.ovf_flag && st.count == COUNT_RESET))
        else $error("wrap did not set overflow flag");

    a_evt_no_flag: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clk_en && evt_reset && !st.ovf_flag)
        |=> (st.count == COUNT_RESET && !st.ovf_flag))
        else $error("event reset wrong or set flag");

    a_write_beats_evt: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clk_en && i_wr_low && (cmp1_evt || cmp2_evt))
        |=> (st.count[BYTE_W-1:0] == $past(i_wdata)))
        else $error("trigger reset overrode write");

    a_rd_low_latch: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clk_en && i_rd_low && i_wide_access_enable && !i_wr_high)
        |=> (st.hold_buf == $past(st.count[COUNT_W-1:BYTE_W])
             && o_rdata == $past(st.count[BYTE_W-1:0])))
        else $error("low read did not latch high byte");

    a_wide_high_isolated: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clk_en && i_wr_high && !i_wr_low && i_wide_access_enable)
        |=> (st.count == $past(st.count) && st.hold_buf == $past(i_wdata)))
        else $error("wide high write touched live count");

    a_irq_gated: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        $past(i_clk_en) |-> (o_overflow_irq_req
            == (o_overflow_irq_flag && $past(i_overflow_irq_enable))))
        else $error("irq request not gated by enable");

    a_sysclk_status: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_clk_en |=> (o_sysclk_from_lp_osc_flag
            == ($past(i_system_clock_select) == SYSCLK_SEL_LP
                && !$past(i_clock_monitor_fail))))
        else $error("sysclk status flag wrong");

    a_async_unarmed: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clk_en && async_mode && !st.armed && !any_write)
        |=> (st.count == $past(st.count)))
        else $error("unarmed async edge was counted");

    a_off_holds: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clk_en && !i_counter_on && !any_write && !evt_reset)
        |=> (st.count == $past(st.count)))
        else $error("count moved while counter off");

    a_adc_start: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_clk_en |=> (o_adc_start == $past(cmp2_evt && i_adc_enable)))
        else $error("conversion start wrong");
endmodule
`default_nettype wire

// ===== tb/ext_clock_model.sv
// Purpose: Far-side clock source for the count pin or LP oscillator
// Assumes: HALF system cycles per half period of the source
// Notes:   Stands low outside bursts and while disabled
`timescale 1ns/1ns
`default_nettype none
module ext_clock_model #(
    parameter int HALF    = 4,
    parameter int STARTUP = 8
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_enable,
    input  wire logic       i_start,
    input  wire logic [3:0] i_edges,
    output logic            o_level,
    output logic            o_busy
);
    int left;
    int phase;
    int warm;
    assign o_busy = (left != 0);
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n || !i_enable) begin
            left    <= 0;
            phase   <= 0;
            warm    <= 0;
            o_level <= 1'b0;
        end else if (warm < STARTUP) begin
            warm <= warm + 1;
        end else if (left == 0) begin
            phase   <= 0;
            o_level <= 1'b0;
            if (i_start) begin
                left <= int'(i_edges);
            end
        end else begin
            o_level <= (phase < HALF);
            if (phase == 2 * HALF - 1) begin
                phase <= 0;
                left  <= left - 1;
            end else begin
                phase <= phase + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/sixteen_bit_timer_with_lp_osc_test.sv
// Purpose: Self-checking bench for the sixteen-bit LP timer
// Assumes: Partner models drive the count pin and LP osc inputs
// Notes:   Short bursts keep the run to a few hundred cycles
`timescale 1ns/1ns
`default_nettype none
module sixteen_bit_timer_with_lp_osc_test;
    import lp_timer_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_rst_n, i_clk_en, i_rd_low, i_rd_high, i_wr_low, i_wr_high;
    logic [BYTE_W-1:0] i_wdata, o_rdata;
    logic i_wide_access_enable, i_counter_on, i_count_source_select;
    logic i_ext_sync_bypass, i_lp_osc_enable, i_overflow_irq_enable;
    logic i_overflow_flag_clear, i_clock_monitor_fail, i_insn_tick;
    logic [SEL_W-1:0] i_input_prescale_select, i_system_clock_select;
    logic i_ext_clk_pin, i_lp_osc_clk, i_cmp1_uses_timer, i_cmp1_match;
    logic i_cmp2_uses_timer, i_cmp2_match, i_adc_enable;
    logic [MODE_W-1:0] i_cmp1_mode, i_cmp2_mode;
    logic [COUNT_W-1:0] o_count;
    logic o_overflow_irq_flag, o_overflow_irq_req, o_lp_osc_enable;
    logic o_sec_run_mode, o_sysclk_from_lp_osc_flag, o_adc_start;
    logic pin_go, osc_go, pin_busy, osc_busy;
    logic [3:0] n_edges;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    always #4 i_sys_clk = ~i_sys_clk;
    lp_timer uut (
        .i_sys_clk, .i_rst_n, .i_clk_en, .i_rd_low, .i_rd_high, .i_wr_low,
        .i_wr_high, .i_wdata, .i_wide_access_enable, .i_counter_on,
        .i_count_source_select, .i_ext_sync_bypass, .i_input_prescale_select,
        .i_lp_osc_enable, .i_overflow_irq_enable, .i_overflow_flag_clear,
        .i_system_clock_select, .i_clock_monitor_fail, .i_insn_tick,
        .i_ext_clk_pin, .i_lp_osc_clk, .i_cmp1_mode, .i_cmp1_uses_timer,
        .i_cmp1_match, .i_cmp2_mode, .i_cmp2_uses_timer, .i_cmp2_match,
        .i_adc_enable, .o_rdata, .o_count, .o_overflow_irq_flag,
        .o_overflow_irq_req, .o_lp_osc_enable, .o_sec_run_mode,
        .o_sysclk_from_lp_osc_flag, .o_adc_start
    );
    ext_clock_model pin_src (.i_sys_clk, .i_rst_n, .i_enable(1'b1),
        .i_start(pin_go), .i_edges(n_edges), .o_level(i_ext_clk_pin),
        .o_busy(pin_busy));
    ext_clock_model osc_src (.i_sys_clk, .i_rst_n, .i_enable(o_lp_osc_enable),
        .i_start(osc_go), .i_edges(n_edges), .o_level(i_lp_osc_clk),
        .o_busy(osc_busy));
    ////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic wr(input bit hi, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_wr_high <= hi;
        i_wr_low  <= !hi;
        i_wdata   <= d;
        @(posedge i_sys_clk);
        i_wr_high <= 1'b0;
        i_wr_low  <= 1'b0;
        #1;
    endtask
    task automatic load(input logic [15:0] v);
        wr(1'b1, v[15:8]);
        wr(1'b0, v[7:0]);
    endtask
    task automatic rd(input bit hi);
        @(posedge i_sys_clk);
        i_rd_high <= hi;
        i_rd_low  <= !hi;
        @(posedge i_sys_clk);
        i_rd_high <= 1'b0;
        i_rd_low  <= 1'b0;
        #1;
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge i_sys_clk);
            i_insn_tick <= 1'b1;
            @(posedge i_sys_clk);
            i_insn_tick <= 1'b0;
        end
        #1;
    endtask
    task automatic cmp(input int u);
        @(posedge i_sys_clk);
        i_cmp1_match <= (u == 1);
        i_cmp2_match <= (u == 2);
        @(posedge i_sys_clk);
        i_cmp1_match <= 1'b0;
        i_cmp2_match <= 1'b0;
        #1;
    endtask
    task automatic burst(input bit osc, input logic [3:0] n);
        @(posedge i_sys_clk);
        n_edges <= n;
        pin_go  <= !osc;
        osc_go  <= osc;
        @(posedge i_sys_clk);
        pin_go <= 1'b0;
        osc_go <= 1'b0;
        #1;
        for (int k = 0; k < 200 && (pin_busy || osc_busy); k++) begin
            @(posedge i_sys_clk);
        end
        cyc(6);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_bytes();
        load(16'habcd);
        chk("direct write", 16'habcd, o_count);
        rd(1'b1);
        chk("direct high", 16'h00ab, o_rdata);
        @(posedge i_sys_clk) i_wide_access_enable <= 1'b1;
        wr(1'b1, 8'h12);
        chk("live high kept", 16'habcd, o_count);
        wr(1'b0, 8'h34);
        chk("wide commit", 16'h1234, o_count);
        @(posedge i_sys_clk) i_wide_access_enable <= 1'b0;
        wr(1'b1, 8'h56);
        @(posedge i_sys_clk) i_wide_access_enable <= 1'b1;
        rd(1'b1);
        chk("buffer read", 16'h0012, o_rdata);
        rd(1'b0);
        chk("low read", 16'h0034, o_rdata);
        rd(1'b1);
        chk("coherent high", 16'h0056, o_rdata);
        @(posedge i_sys_clk) i_wide_access_enable <= 1'b0;
    endtask
    task automatic t_prescale();
        @(posedge i_sys_clk) i_counter_on <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            @(posedge i_sys_clk) i_input_prescale_select <= SEL_W'(s);
            load(16'h0000);
            tick((1 << s) - 1);
            chk("below ratio", 16'h0000, o_count);
            tick(1);
            chk("at ratio", 16'h0001, o_count);
        end
        @(posedge i_sys_clk) i_counter_on <= 1'b0;
        @(posedge i_sys_clk) i_input_prescale_select <= 2'h0;
        tick(1);
        chk("held when off", 16'h0001, o_count);
        @(posedge i_sys_clk) i_counter_on <= 1'b1;
        @(posedge i_sys_clk) i_input_prescale_select <= 2'h1;
        load(16'h0000);
        tick(1);
        wr(1'b1, 8'h00);
        tick(1);
        chk("high write keeps prescale", 16'h0001, o_count);
        tick(1);
        wr(1'b0, 8'h01);
        tick(1);
        chk("low write clears prescale", 16'h0001, o_count);
        tick(1);
        chk("count after clear", 16'h0002, o_count);
        @(posedge i_sys_clk) i_input_prescale_select <= 2'h0;
    endtask
    task automatic t_overflow();
        load(16'hffff);
        tick(1);
        chk("wrap", 16'h0000, o_count);
        chk("flag set", 16'h1, o_overflow_irq_flag);
        chk("masked", 16'h0, o_overflow_irq_req);
        @(posedge i_sys_clk) i_overflow_irq_enable <= 1'b1;
        cyc(2);
        chk("request", 16'h1, o_overflow_irq_req);
        @(posedge i_sys_clk) i_overflow_flag_clear <= 1'b1;
        @(posedge i_sys_clk) i_overflow_flag_clear <= 1'b0;
        cyc(2);
        chk("request dropped", 16'h0, o_overflow_irq_req);
        load(16'hffff);
        tick(1);
        chk("request on wrap", 16'h1, o_overflow_irq_req);
        @(posedge i_sys_clk) i_overflow_flag_clear <= 1'b1;
        @(posedge i_sys_clk) i_overflow_flag_clear <= 1'b0;
        cyc(2);
        chk("flag cleared", 16'h0, o_overflow_irq_flag);
    endtask
    task automatic t_event();
        @(posedge i_sys_clk);
        i_cmp1_mode <= MODE_SPECIAL_EVT;
        i_cmp2_mode <= MODE_SPECIAL_EVT;
        load(16'h1234);
        cmp(2);
        chk("unit two reset", 16'h0000, o_count);
        chk("conversion start", 16'h1, o_adc_start);
        chk("no flag", 16'h0, o_overflow_irq_flag);
        cyc(1);
        chk("start ends", 16'h0, o_adc_start);
        load(16'h1234);
        cmp(1);
        chk("unit one reset", 16'h0000, o_count);
        chk("no conversion", 16'h0, o_adc_start);
        @(posedge i_sys_clk) i_cmp1_mode <= 4'ha;
        load(16'h1234);
        cmp(1);
        chk("other mode", 16'h1234, o_count);
        @(posedge i_sys_clk) i_cmp1_mode <= MODE_SPECIAL_EVT;
        @(posedge i_sys_clk);
        i_wr_low     <= 1'b1;
        i_wdata      <= 8'h77;
        i_cmp1_match <= 1'b1;
        @(posedge i_sys_clk);
        i_wr_low     <= 1'b0;
        i_cmp1_match <= 1'b0;
        #1;
        chk("write wins", 16'h1277, o_count);
    endtask
    task automatic t_clock();
        @(posedge i_sys_clk) i_lp_osc_enable <= 1'b1;
        cyc(2);
        chk("osc on", 16'h1, o_lp_osc_enable);
        @(posedge i_sys_clk) i_system_clock_select <= SYSCLK_SEL_LP;
        cyc(2);
        chk("secondary run", 16'h1, o_sec_run_mode);
        chk("status set", 16'h1, o_sysclk_from_lp_osc_flag);
        chk("osc kept", 16'h1, o_lp_osc_enable);
        @(posedge i_sys_clk) i_clock_monitor_fail <= 1'b1;
        cyc(2);
        chk("switched away", 16'h0, o_sysclk_from_lp_osc_flag);
        @(posedge i_sys_clk) i_clock_monitor_fail <= 1'b0;
        @(posedge i_sys_clk) i_system_clock_select <= 2'h0;
        cyc(2);
        chk("primary clock", 16'h0, o_sysclk_from_lp_osc_flag);
        @(posedge i_sys_clk) i_lp_osc_enable <= 1'b0;
        cyc(2);
        chk("osc off", 16'h0, o_lp_osc_enable);
    endtask
    task automatic t_external();
        @(posedge i_sys_clk) i_count_source_select <= 1'b1;
        load(16'h0000);
        burst(1'b0, 4'h3);
        chk("synced pin", 16'h0003, o_count);
        @(posedge i_sys_clk) i_lp_osc_enable <= 1'b1;
        cyc(12);
        load(16'h0000);
        burst(1'b1, 4'h2);
        chk("osc edges", 16'h0002, o_count);
        @(posedge i_sys_clk) i_lp_osc_enable <= 1'b0;
        @(posedge i_sys_clk) i_ext_sync_bypass <= 1'b1;
        load(16'h0000);
        burst(1'b0, 4'h3);
        chk("first rise dropped", 16'h0002, o_count);
        wr(1'b1, 8'h80);
        chk("msb preload", 16'h8002, o_count);
        @(posedge i_sys_clk);
        n_edges <= 4'h2;
        pin_go  <= 1'b1;
        @(posedge i_sys_clk) pin_go <= 1'b0;
        for (int k = 0; k < 40 && o_rdata != 8'h03; k++) begin
            rd(1'b0);
        end
        chk("polled increment", 16'h0003, o_rdata);
        wr(1'b0, 8'h10);
        cyc(8);
        chk("update after poll", 16'h8010, o_count);
        cmp(1);
        chk("async keeps count", 16'h8010, o_count);
    endtask
    initial begin
        {i_rd_low, i_rd_high, i_wr_low, i_wr_high, i_wdata} = '0;
        {i_wide_access_enable, i_counter_on, i_count_source_select} = '0;
        {i_ext_sync_bypass, i_lp_osc_enable, i_overflow_irq_enable} = '0;
        {i_overflow_flag_clear, i_clock_monitor_fail, i_insn_tick} = '0;
        {i_input_prescale_select, i_system_clock_select} = '0;
        {i_cmp1_match, i_cmp2_match, i_cmp1_mode, i_cmp2_mode} = '0;
        {i_cmp1_uses_timer, i_cmp2_uses_timer, i_adc_enable} = 3'h7;
        {pin_go, osc_go, n_edges} = '0;
        i_clk_en = 1'b1;
        i_rst_n  = 1'b0;
        cyc(5);
        @(posedge i_sys_clk) i_rst_n <= 1'b1;
        cyc(1);
        chk("reset count", 16'h0000, o_count);
        t_bytes();
        t_prescale();
        t_overflow();
        t_event();
        t_clock();
        t_external();
        wrap_up();
    end
endmodule
`default_nettype wire
